// [bench/pcs_core_monitor.sv]
`timescale 1ns/1ps
// port-level property checks for program flow and return stack
module pcs_core_monitor (
  input wire logic clk_sys_in, // core clock
  input wire logic sys_rst_in, // device reset
  input wire logic stack_fault_reset_enable_in, // fault config
  input wire pcs_pkg::pcs_instr_t instr_in, // flow step
  input wire pcs_pkg::pcs_fwr_t file_wr_in, // file write
  input wire pcs_pkg::pcs_flags_t flags_in, // flag results
  input wire pcs_pkg::pcs_pwr_t pwr_evt_in, // power events
  input wire logic ovf_clr_in, // overflow clear
  input wire logic unf_clr_in, // underflow clear
  input wire logic [12:0] rd_addr_in, // read address
  input wire logic [7:0] rd_data_out, // read data
  input wire logic rd_hit_out, // read hit
  input wire logic [14:0] pc_out, // program counter
  input wire logic [6:0] pc_high_latch_out, // high latch
  input wire logic [4:0] status_out, // status bits
  input wire logic [4:0] stack_pointer_out, // pointer
  input wire logic [14:0] top_of_stack_out, // top entry
  input wire logic stack_overflow_flag_out, // overflow
  input wire logic stack_underflow_flag_out, // underflow
  input wire logic stack_fault_reset_out // fault pulse
);
  logic [14:0] pc_q;
  logic [6:0] latch_q;
  pcs_pkg::pcs_instr_t instr_q;
  pcs_pkg::pcs_fwr_t fwr_q;
  logic borrow_q;
  logic [1:0] live_q;
  logic pc_low_wr;
  logic push_op;
  logic pop_op;
  logic no_flt;
  // previous-cycle copies and cycles since reset release
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pc_q <= 15'h0000;
      latch_q <= 7'h00;
      instr_q <= '0;
      fwr_q <= '0;
      borrow_q <= 1'b0;
      live_q <= 2'h0;
    end
    else
    begin
      pc_q <= pc_out;
      latch_q <= pc_high_latch_out;
      instr_q <= instr_in;
      fwr_q <= file_wr_in;
      borrow_q <= flags_in.borrow;
      live_q <= {live_q[0], 1'b1};
    end
  end
  // decoded request kinds
  assign pc_low_wr = file_wr_in.en && file_wr_in.addr[6:0] == pcs_pkg::PCS_OFS_PC_LOW;
  assign push_op = instr_in.op inside {pcs_pkg::pcs_op_call, pcs_pkg::pcs_op_call_acc, pcs_pkg::pcs_op_irq};
  assign pop_op = instr_in.op inside {pcs_pkg::pcs_op_return, pcs_pkg::pcs_op_ret_lit, pcs_pkg::pcs_op_ret_int};
  assign no_flt = !(push_op && stack_pointer_out == 5'h0f) && !(pop_op && stack_pointer_out == 5'h1f);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_push_full;
    push_op && stack_pointer_out == pcs_pkg::PCS_SP_TOP;
  endsequence
  sequence s_fault_done;
    pc_out == 15'h0000 && stack_pointer_out == 5'h1f && stack_fault_reset_out ##0 stack_overflow_flag_out;
  endsequence
  property p_call;
    instr_in.op == pcs_pkg::pcs_op_call && !pc_low_wr && no_flt |=> pc_out == {latch_q[6:3], instr_q.operand};
  endproperty
  a_call: assert property (p_call) else $error("call target wrong");
  property p_br_acc;
    instr_in.op == pcs_pkg::pcs_op_br_acc && !pc_low_wr |=> pc_out == pc_q + 15'h0001 + {7'h00, instr_q.accum};
  endproperty
  a_br_acc: assert property (p_br_acc) else $error("accumulator branch wrong");
  property p_pc_low;
    pc_low_wr && instr_in.op == pcs_pkg::pcs_op_hold |=> pc_out == {latch_q, fwr_q.data};
  endproperty
  a_pc_low: assert property (p_pc_low) else $error("low byte write wrong");
  property p_latch_keep;
    (push_op || pop_op) && no_flt && !file_wr_in.en |=> pc_high_latch_out == latch_q;
  endproperty
  a_latch_keep: assert property (p_latch_keep) else $error("latch moved on stack op");
  property p_status_keep;
    pwr_evt_in == '0 |=> $stable(status_out[4:3]);
  endproperty
  a_status_keep: assert property (p_status_keep) else $error("reset status bits changed");
  property p_borrow;
    flags_in.upd_c && flags_in.sub |=> status_out[pcs_pkg::PCS_BIT_C] == borrow_q;
  endproperty
  a_borrow: assert property (p_borrow) else $error("borrow not in carry");
  property p_wrap;
    s_push_full ##0 !stack_fault_reset_enable_in |=> stack_pointer_out == 5'h00 && stack_overflow_flag_out;
  endproperty
  a_wrap: assert property (p_wrap) else $error("overflow wrap wrong");
  property p_fault;
    s_push_full ##0 stack_fault_reset_enable_in && live_q[1] |=> s_fault_done;
  endproperty
  a_fault: assert property (p_fault) else $error("overflow fault reset wrong");
  property p_tos_empty;
    stack_fault_reset_enable_in && live_q[1] && stack_pointer_out == 5'h1f |-> top_of_stack_out == 15'h0000;
  endproperty
  a_tos_empty: assert property (p_tos_empty) else $error("empty top not zero");
  property p_read_sp;
    rd_addr_in == pcs_pkg::PCS_ADDR_STACK_PTR |=> rd_hit_out && rd_data_out == {3'h0, $past(stack_pointer_out)};
  endproperty
  a_read_sp: assert property (p_read_sp) else $error("pointer read wrong");
endmodule : pcs_core_monitor

// [bench/pcs_core_test.sv]
`timescale 1ns/1ps
// directed checks; instance 0 wraps, instance 1 resets on stack faults
module pcs_core_test;
  logic clk_sys_in;
  logic sys_rst_in;
  pcs_pkg::pcs_instr_t instr;
  pcs_pkg::pcs_fwr_t fwr;
  pcs_pkg::pcs_flags_t flg;
  pcs_pkg::pcs_pwr_t pwr;
  logic ovf_clr;
  logic unf_clr;
  logic [12:0] rd_addr;
  logic [7:0] rd_data [2];
  logic rd_hit [2];
  logic [14:0] pc [2];
  logic [6:0] lat [2];
  logic [4:0] st [2];
  logic [4:0] sp [2];
  logic [14:0] tos [2];
  logic ovf [2];
  logic unf [2];
  logic flt [2];
  logic [14:0] p;
  int n_errors;
  int n_tests;
  // two instances differing only in fault configuration
  for (genvar g = 0; g < 2; g++)
  begin : g_dut
    pcs_core dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .stack_fault_reset_enable_in(g == 1),
      .instr_in(instr), .file_wr_in(fwr), .flags_in(flg), .pwr_evt_in(pwr), .ovf_clr_in(ovf_clr),
      .unf_clr_in(unf_clr), .rd_addr_in(rd_addr), .rd_data_out(rd_data[g]), .rd_hit_out(rd_hit[g]),
      .pc_out(pc[g]), .pc_high_latch_out(lat[g]), .status_out(st[g]), .stack_pointer_out(sp[g]),
      .top_of_stack_out(tos[g]), .stack_overflow_flag_out(ovf[g]), .stack_underflow_flag_out(unf[g]),
      .stack_fault_reset_out(flt[g]));
  end
  // clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  task automatic tick();
    @(posedge clk_sys_in);
    #1;
  endtask : tick
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one flow step then one hold cycle
  task automatic step(input pcs_pkg::pcs_op_t op, input logic [10:0] opnd, input logic [7:0] acc);
    instr = '{op, opnd, acc};
    tick();
    instr.op = pcs_pkg::pcs_op_hold;
    tick();
  endtask : step
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    fwr = '{1'b1, a, d};
    tick();
    fwr.en = 1'b0;
    tick();
  endtask : wr
  task automatic rd(input logic [12:0] a, input logic [7:0] exp);
    rd_addr = a;
    tick();
    chk(rd_data[0], exp);
  endtask : rd
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  // watchdog
  initial
  begin
    #100000;
    n_errors++;
    report_and_stop();
  end
  // main sequence
  initial
  begin
    sys_rst_in = 1'b1;
    instr = '0;
    fwr = '0;
    flg = '0;
    pwr = '0;
    ovf_clr = 1'b0;
    unf_clr = 1'b0;
    rd_addr = 13'h0000;
    repeat (20) @(posedge clk_sys_in);
    #1 sys_rst_in = 1'b0;
    tick();
    tick();
    chk(pc[1], 15'h0000);
    chk(st[0], pcs_pkg::PCS_STATUS_RST);
    chk(sp[0], 5'h1f);
    chk(tos[1], 15'h0000);
    wr(13'h008a, 8'h5a);
    chk(lat[0], 7'h5a);
    wr(13'h0102, 8'hf0 + 8'h20);
    chk(pc[0], {7'h5a, 8'h10});
    rd(13'h0002, 8'h10);
    rd(13'h1e13, 8'h00);
    chk(rd_hit[0], 1'b0);
    p = pc[0];
    step(pcs_pkg::pcs_op_call, 11'h123, 8'h00);
    chk(pc[0], {4'hb, 11'h123});
    chk(sp[0], 5'h00);
    chk(tos[0], p + 15'h0001);
    chk(lat[0], 7'h5a);
    step(pcs_pkg::pcs_op_call_acc, 11'h000, 8'h77);
    chk(pc[0], {7'h5a, 8'h77});
    chk(tos[0], 15'h5924);
    step(pcs_pkg::pcs_op_irq, 11'h000, 8'h00);
    chk(pc[0], pcs_pkg::PCS_INT_VECTOR);
    chk(tos[0], {7'h5a, 8'h77});
    step(pcs_pkg::pcs_op_ret_int, 11'h000, 8'h00);
    chk(pc[0], {7'h5a, 8'h77});
    step(pcs_pkg::pcs_op_return, 11'h000, 8'h00);
    chk(pc[0], 15'h5924);
    step(pcs_pkg::pcs_op_ret_lit, 11'h000, 8'h00);
    chk(pc[0], p + 15'h0001);
    chk(sp[0], 5'h1f);
    p = pc[0];
    step(pcs_pkg::pcs_op_br_acc, 11'h000, 8'hf0);
    chk(pc[0], p + 15'h0001 + 15'h00f0);
    p = pc[0];
    step(pcs_pkg::pcs_op_br_imm, 11'h1f0, 8'h00);
    chk(pc[0], p + 15'h0001 - 15'h0010);
    p = pc[0];
    step(pcs_pkg::pcs_op_next, 11'h000, 8'h00);
    chk(pc[0], p + 15'h0001);
    // status: reset bits only move on power events
    pwr.wdt_timeout = 1'b1;
    tick();
    pwr = '0;
    tick();
    wr(13'h0003, 8'hff);
    chk(st[0], 5'h0f);
    flg = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    wr(13'h0083, 8'h00);
    chk(st[0], 5'h0d);
    flg = '0;
    pwr.sleep = 1'b1;
    tick();
    pwr = '0;
    tick();
    chk(st[0], 5'h15);
    pwr.clrwdt = 1'b1;
    tick();
    pwr = '0;
    tick();
    chk(st[0], 5'h1d);
    // software stack window
    wr(pcs_pkg::PCS_ADDR_STACK_PTR, 8'h03);
    wr(pcs_pkg::PCS_ADDR_TOP_LOW, 8'hab);
    wr(pcs_pkg::PCS_ADDR_TOP_HIGH, 8'h12);
    chk(tos[0], 15'h12ab);
    rd(pcs_pkg::PCS_ADDR_STACK_PTR, 8'h03);
    rd(pcs_pkg::PCS_ADDR_TOP_HIGH, 8'h12);
    rd(pcs_pkg::PCS_ADDR_TOP_LOW, 8'hab);
    wr(pcs_pkg::PCS_ADDR_STACK_PTR, 8'h1f);
    // fill the stack then push once more
    for (int i = 0; i < 16; i++)
      step(pcs_pkg::pcs_op_call, 11'(i), 8'h00);
    chk(ovf[0], 1'b0);
    p = pc[0];
    // the fault pulse stands only in the cycle after the faulting push
    instr = '{pcs_pkg::pcs_op_call, 11'h7ff, 8'h00};
    tick();
    chk(flt[1], 1'b1);
    instr.op = pcs_pkg::pcs_op_hold;
    tick();
    chk(flt[1], 1'b0);
    chk(sp[0], 5'h00);
    chk(tos[0], p + 15'h0001);
    chk(ovf[0], 1'b1);
    chk(pc[1], 15'h0000);
    chk(ovf[1], 1'b1);
    ovf_clr = 1'b1;
    tick();
    ovf_clr = 1'b0;
    tick();
    chk(ovf[0], 1'b0);
    // pop from an empty stack
    wr(pcs_pkg::PCS_ADDR_STACK_PTR, 8'h1f);
    instr = '{pcs_pkg::pcs_op_return, 11'h000, 8'h00};
    tick();
    chk(flt[1], 1'b1);
    chk(pc[1], 15'h0000);
    instr.op = pcs_pkg::pcs_op_hold;
    tick();
    chk(unf[0], 1'b1);
    chk(sp[0], 5'h0e);
    chk(pc[0], {4'hb, 11'h00e} + 15'h0001);
    chk(unf[1], 1'b1);
    chk(sp[1], 5'h1f);
    unf_clr = 1'b1;
    tick();
    unf_clr = 1'b0;
    tick();
    chk(unf[0], 1'b0);
    report_and_stop();
  end
endmodule : pcs_core_test

bind pcs_core pcs_core_monitor mon (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
  .stack_fault_reset_enable_in(stack_fault_reset_enable_in), .instr_in(instr_in), .file_wr_in(file_wr_in),
  .flags_in(flags_in), .pwr_evt_in(pwr_evt_in), .ovf_clr_in(ovf_clr_in), .unf_clr_in(unf_clr_in),
  .rd_addr_in(rd_addr_in), .rd_data_out(rd_data_out), .rd_hit_out(rd_hit_out), .pc_out(pc_out),
  .pc_high_latch_out(pc_high_latch_out), .status_out(status_out), .stack_pointer_out(stack_pointer_out),
  .top_of_stack_out(top_of_stack_out), .stack_overflow_flag_out(stack_overflow_flag_out),
  .stack_underflow_flag_out(stack_underflow_flag_out), .stack_fault_reset_out(stack_fault_reset_out));

// [hw/pcs_core.sv]
`timescale 1ns/1ps
module pcs_core (
  input wire logic clk_sys_in, // core clock, 100 MHz
  input wire logic sys_rst_in, // device reset, async, high
  input wire logic stack_fault_reset_enable_in, // configuration bit
  input wire pcs_pkg::pcs_instr_t instr_in, // flow step of this cycle
  input wire pcs_pkg::pcs_fwr_t file_wr_in, // file write of this cycle
  input wire pcs_pkg::pcs_flags_t flags_in, // arithmetic flag results
  input wire pcs_pkg::pcs_pwr_t pwr_evt_in, // watchdog and sleep events
  input wire logic ovf_clr_in, // clear overflow flag
  input wire logic unf_clr_in, // clear underflow flag
  input wire logic [12:0] rd_addr_in, // file read address
  output logic [7:0] rd_data_out, // file read data, next cycle
  output logic rd_hit_out, // read address is held here
  output logic [14:0] pc_out, // program counter
  output logic [6:0] pc_high_latch_out, // high latch
  output logic [4:0] status_out, // status bits four to zero
  output logic [4:0] stack_pointer_out, // stack pointer
  output logic [14:0] top_of_stack_out, // entry at pointer
  output logic stack_overflow_flag_out, // sticky overflow
  output logic stack_underflow_flag_out, // sticky underflow
  output logic stack_fault_reset_out // one-cycle fault reset pulse
);

  logic [14:0] pc_reg;
  logic [14:0] pc_next;
  logic [6:0] latch_reg;
  logic [4:0] status_reg;
  logic [4:0] status_next;
  logic [4:0] sp_reg;
  logic [4:0] sp_next;
  logic ovf_reg;
  logic unf_reg;
  logic fault_rst_reg;
  logic fault_cfg_reg;
  logic fault_cfg_done_reg;
  logic [7:0] rd_data_reg;
  logic rd_hit_reg;

  logic [14:0] pc_inc;
  logic [14:0] ret_addr;
  logic [14:0] tos_raw;
  logic [14:0] tos_view;
  logic is_push;
  logic is_pop;
  logic push_ovf;
  logic pop_unf;
  logic fault_now;
  logic [4:0] sp_push;
  logic [4:0] sp_pop;
  logic wr_pc_low;
  logic wr_status;
  logic wr_latch;
  logic wr_sp;
  logic wr_top_low;
  logic wr_top_high;
  logic ram_wr_en;
  logic [3:0] ram_wr_idx;
  logic [14:0] ram_wr_data;
  logic flag_c;
  logic flag_digit;
  logic sp_empty;

  // file write decode; core registers mirror into every bank
  assign wr_pc_low = file_wr_in.en && (file_wr_in.addr[6:0] == pcs_pkg::PCS_OFS_PC_LOW);
  assign wr_status = file_wr_in.en && (file_wr_in.addr[6:0] == pcs_pkg::PCS_OFS_STATUS);
  assign wr_latch = file_wr_in.en && (file_wr_in.addr[6:0] == pcs_pkg::PCS_OFS_PC_LATCH);
  assign wr_sp = file_wr_in.en && (file_wr_in.addr == pcs_pkg::PCS_ADDR_STACK_PTR);
  assign wr_top_low = file_wr_in.en && (file_wr_in.addr == pcs_pkg::PCS_ADDR_TOP_LOW);
  assign wr_top_high = file_wr_in.en && (file_wr_in.addr == pcs_pkg::PCS_ADDR_TOP_HIGH);

  // address of the following instruction
  assign pc_inc = pc_reg + pcs_pkg::PCS_PC_ONE;

  // return address saved by a push
  always_comb
  begin
    ret_addr = pc_inc;
    if (instr_in.op == pcs_pkg::pcs_op_irq)
    begin
      ret_addr = pc_reg;
    end
  end

  // push and pop classification
  // push pop sources
  assign is_push = (instr_in.op == pcs_pkg::pcs_op_call) || (instr_in.op == pcs_pkg::pcs_op_call_acc) ||
                   (instr_in.op == pcs_pkg::pcs_op_irq);
  assign is_pop = (instr_in.op == pcs_pkg::pcs_op_return) || (instr_in.op == pcs_pkg::pcs_op_ret_lit) ||
                  (instr_in.op == pcs_pkg::pcs_op_ret_int);

  // overflow past sixteenth level, underflow past the first
  // fault detection
  assign push_ovf = is_push && (sp_reg == pcs_pkg::PCS_SP_TOP);
  assign pop_unf = is_pop && (sp_reg == pcs_pkg::PCS_SP_RST);
  assign fault_now = fault_cfg_reg && (push_ovf || pop_unf);

  // pointer moves; wrapping keeps the pointer inside the sixteen entries
  // increment then write
  assign sp_push = push_ovf ? pcs_pkg::PCS_SP_FIRST : sp_reg + 5'h01;
  assign sp_pop = pop_unf ? pcs_pkg::PCS_SP_UNF_WRAP : sp_reg - 5'h01;

  // empty stack detection
  assign sp_empty = (sp_reg == pcs_pkg::PCS_SP_RST);

  // capture the fault reset configuration once, at reset release
  // static configuration
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      fault_cfg_reg <= 1'b0;
      fault_cfg_done_reg <= 1'b0;
    end
    else if (!fault_cfg_done_reg)
    begin
      fault_cfg_reg <= stack_fault_reset_enable_in;
      fault_cfg_done_reg <= 1'b1;
    end
  end

  // program counter next value
  always_comb
  begin
    pc_next = pc_reg;
    unique case (instr_in.op)
      pcs_pkg::pcs_op_hold:
      begin
        pc_next = pc_reg;
      end
      pcs_pkg::pcs_op_next:
      begin
        pc_next = pc_inc;
      end
      pcs_pkg::pcs_op_call:
      begin
        pc_next = {latch_reg[6:3], instr_in.operand};
      end
      pcs_pkg::pcs_op_call_acc:
      begin
        pc_next = {latch_reg, instr_in.accum};
      end
      pcs_pkg::pcs_op_br_acc:
      begin
        pc_next = pc_inc + {7'h00, instr_in.accum};
      end
      pcs_pkg::pcs_op_br_imm:
      begin
        pc_next = pc_inc + {{6{instr_in.operand[8]}}, instr_in.operand[8:0]};
      end
      pcs_pkg::pcs_op_return, pcs_pkg::pcs_op_ret_lit, pcs_pkg::pcs_op_ret_int:
      begin
        pc_next = tos_raw;
      end
      pcs_pkg::pcs_op_irq:
      begin
        pc_next = pcs_pkg::PCS_INT_VECTOR;
      end
      default:
      begin
        pc_next = pc_reg;
      end
    endcase
    // low byte write loads all bits
    if (wr_pc_low)
    begin
      pc_next = {latch_reg, file_wr_in.data};
    end
  end

  // program counter register
  // fifteen bit counter
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pc_reg <= pcs_pkg::PCS_PC_RST;
    end
    else if (fault_now)
    begin
      pc_reg <= pcs_pkg::PCS_PC_RST;
    end
    else
    begin
      pc_reg <= pc_next;
    end
  end

  // high latch, written only by file writes and cleared by reset or a fault reset
  // latch untouched by stack except a fault reset
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      latch_reg <= pcs_pkg::PCS_LATCH_RST;
    end
    else if (fault_now)
    begin
      latch_reg <= pcs_pkg::PCS_LATCH_RST;
    end
    else if (wr_latch)
    begin
      latch_reg <= file_wr_in.data[6:0];
    end
  end

  // carry flags; subtraction reports borrows
  // borrow outputs
  assign flag_c = flags_in.sub ? flags_in.borrow : flags_in.carry;
  assign flag_digit = flags_in.sub ? flags_in.dborrow : flags_in.dcarry;

  // status next value
  always_comb
  begin
    status_next = status_reg;
    if (wr_status)
    begin
      status_next[pcs_pkg::PCS_BIT_Z:0] = file_wr_in.data[pcs_pkg::PCS_BIT_Z:0];
    end
    if (flags_in.upd_z)
    begin
      status_next[pcs_pkg::PCS_BIT_Z] = flags_in.zero;
    end
    if (flags_in.upd_digit)
    begin
      status_next[pcs_pkg::PCS_BIT_DIGIT] = flag_digit;
    end
    if (flags_in.upd_c)
    begin
      status_next[pcs_pkg::PCS_BIT_C] = flag_c;
    end
    // hardware causes for timeout and powerdown
    if (pwr_evt_in.clrwdt)
    begin
      status_next[pcs_pkg::PCS_BIT_TIMEOUT] = 1'b1;
      status_next[pcs_pkg::PCS_BIT_PWRDN] = 1'b1;
    end
    if (pwr_evt_in.sleep)
    begin
      status_next[pcs_pkg::PCS_BIT_TIMEOUT] = 1'b1;
      status_next[pcs_pkg::PCS_BIT_PWRDN] = 1'b0;
    end
    if (pwr_evt_in.wdt_timeout)
    begin
      status_next[pcs_pkg::PCS_BIT_TIMEOUT] = 1'b0;
    end
  end

  // status register
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      status_reg <= pcs_pkg::PCS_STATUS_RST;
    end
    else
    begin
      status_reg <= status_next;
    end
  end

  // stack pointer next value; stack moves win over a pointer write
  always_comb
  begin
    sp_next = sp_reg;
    if (wr_sp)
    begin
      sp_next = file_wr_in.data[4:0];
    end
    if (is_push)
    begin
      sp_next = sp_push;
    end
    else if (is_pop)
    begin
      sp_next = sp_pop;
    end
  end

  // stack pointer register
  // empty after reset
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sp_reg <= pcs_pkg::PCS_SP_RST;
    end
    else if (fault_now)
    begin
      sp_reg <= pcs_pkg::PCS_SP_RST;
    end
    else
    begin
      sp_reg <= sp_next;
    end
  end

  // sticky fault flags; a new fault wins over a clear
  // flags in both modes
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ovf_reg <= 1'b0;
      unf_reg <= 1'b0;
    end
    else
    begin
      ovf_reg <= push_ovf || (ovf_reg && !ovf_clr_in);
      unf_reg <= pop_unf || (unf_reg && !unf_clr_in);
    end
  end

  // fault reset pulse toward the device reset logic
  // device reset pulse
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      fault_rst_reg <= 1'b0;
    end
    else
    begin
      fault_rst_reg <= fault_now;
    end
  end

  // stack write port: pushes, or byte writes through top of stack
  always_comb
  begin
    ram_wr_en = 1'b0;
    ram_wr_idx = sp_reg[3:0];
    ram_wr_data = tos_raw;
    if (is_push && !fault_now)
    begin
      ram_wr_en = 1'b1;
      ram_wr_idx = sp_push[3:0];
      ram_wr_data = ret_addr;
    end
    else if (wr_top_low && !is_pop)
    begin
      ram_wr_en = 1'b1;
      ram_wr_data = {tos_raw[14:8], file_wr_in.data};
    end
    else if (wr_top_high && !is_pop)
    begin
      ram_wr_en = 1'b1;
      ram_wr_data = {file_wr_in.data[6:0], tos_raw[7:0]};
    end
  end

  pcs_stack_ram u_stack_ram (
    .clk_sys_in(clk_sys_in),
    .wr_en_in(ram_wr_en),
    .wr_idx_in(ram_wr_idx),
    .wr_data_in(ram_wr_data),
    .rd_idx_in(sp_reg[3:0]),
    .rd_data_out(tos_raw)
  );

  // top of stack view; empty stack reads zero in fault mode
  // zero top when empty
  assign tos_view = (sp_empty && fault_cfg_reg) ? pcs_pkg::PCS_PC_RST : tos_raw;

  // registered file read port
  // unheld locations read zero
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rd_data_reg <= pcs_pkg::PCS_RD_RST;
      rd_hit_reg <= 1'b0;
    end
    else
    begin
      rd_hit_reg <= 1'b1;
      if (rd_addr_in[6:0] == pcs_pkg::PCS_OFS_PC_LOW)
      begin
        rd_data_reg <= pc_reg[7:0];
      end
      else if (rd_addr_in[6:0] == pcs_pkg::PCS_OFS_STATUS)
      begin
        rd_data_reg <= {3'h0, status_reg};
      end
      else if (rd_addr_in[6:0] == pcs_pkg::PCS_OFS_PC_LATCH)
      begin
        rd_data_reg <= {1'b0, latch_reg};
      end
      else if (rd_addr_in == pcs_pkg::PCS_ADDR_STACK_PTR)
      begin
        rd_data_reg <= {3'h0, sp_reg};
      end
      else if (rd_addr_in == pcs_pkg::PCS_ADDR_TOP_LOW)
      begin
        rd_data_reg <= tos_view[7:0];
      end
      else if (rd_addr_in == pcs_pkg::PCS_ADDR_TOP_HIGH)
      begin
        rd_data_reg <= {1'b0, tos_view[14:8]};
      end
      else
      begin
        rd_data_reg <= pcs_pkg::PCS_RD_RST;
        rd_hit_reg <= 1'b0;
      end
    end
  end

  // outputs
  assign rd_data_out = rd_data_reg;
  assign rd_hit_out = rd_hit_reg;
  assign pc_out = pc_reg;
  assign pc_high_latch_out = latch_reg;
  assign status_out = status_reg;
  assign stack_pointer_out = sp_reg;
  assign top_of_stack_out = tos_view;
  assign stack_overflow_flag_out = ovf_reg;
  assign stack_underflow_flag_out = unf_reg;
  assign stack_fault_reset_out = fault_rst_reg;

endmodule : pcs_core

// [hw/pcs_stack_ram.sv]
`timescale 1ns/1ps
// return stack storage: one write port, one asynchronous read port
module pcs_stack_ram (
  input wire logic clk_sys_in, // core clock
  input wire logic wr_en_in, // write strobe
  input wire logic [3:0] wr_idx_in, // entry written
  input wire logic [14:0] wr_data_in, // value written
  input wire logic [3:0] rd_idx_in, // entry read
  output logic [14:0] rd_data_out // entry contents
);

  logic [14:0] mem [pcs_pkg::PCS_STACK_DEPTH];

  // entry storage, no reset on the array
  always_ff @(posedge clk_sys_in)
  begin
    if (wr_en_in)
    begin
      mem[wr_idx_in] <= wr_data_in;
    end
  end

  // read path for top of stack and pops
  assign rd_data_out = mem[rd_idx_in];

endmodule : pcs_stack_ram

// [shared/pcs_pkg.sv]
// program counter and return stack: shared constants and carriers
package pcs_pkg;

  // core register offsets, mirrored into every bank (low seven address bits)
  localparam logic [6:0] PCS_OFS_PC_LOW = 7'h02;
  localparam logic [6:0] PCS_OFS_STATUS = 7'h03;
  localparam logic [6:0] PCS_OFS_PC_LATCH = 7'h0a;
  // stack access registers, bank 63 only (full file address)
  localparam logic [12:0] PCS_ADDR_STACK_PTR = 13'h1fed;
  localparam logic [12:0] PCS_ADDR_TOP_LOW = 13'h1fee;
  localparam logic [12:0] PCS_ADDR_TOP_HIGH = 13'h1fef;

  // status register field positions
  localparam int PCS_BIT_TIMEOUT = 4;
  localparam int PCS_BIT_PWRDN = 3;
  localparam int PCS_BIT_Z = 2;
  localparam int PCS_BIT_DIGIT = 1;
  localparam int PCS_BIT_C = 0;

  // values after reset
  localparam logic [14:0] PCS_PC_RST = 15'h0000;
  localparam logic [6:0] PCS_LATCH_RST = 7'h00;
  localparam logic [4:0] PCS_STATUS_RST = 5'h18;
  localparam logic [4:0] PCS_SP_RST = 5'h1f;
  localparam logic [7:0] PCS_RD_RST = 8'h00;

  // stack geometry and pointer landmarks
  localparam int PCS_STACK_DEPTH = 16;
  localparam int PCS_PC_W = 15;
  localparam logic [4:0] PCS_SP_TOP = 5'h0f;
  localparam logic [4:0] PCS_SP_FIRST = 5'h00;
  localparam logic [4:0] PCS_SP_UNF_WRAP = 5'h0e;
  localparam logic [14:0] PCS_PC_ONE = 15'h0001;

  // interrupt vector address, plain default
  localparam logic [14:0] PCS_INT_VECTOR = 15'h0004;

  // program flow step requested by the sequencer
  typedef enum logic [3:0] {
    pcs_op_hold,
    pcs_op_next,
    pcs_op_call,
    pcs_op_call_acc,
    pcs_op_br_acc,
    pcs_op_br_imm,
    pcs_op_return,
    pcs_op_ret_lit,
    pcs_op_ret_int,
    pcs_op_irq
  } pcs_op_t;

  // one executed instruction as seen by program flow
  typedef struct packed {
    pcs_op_t op;
    logic [10:0] operand;
    logic [7:0] accum;
  } pcs_instr_t;

  // file register write of the executing instruction
  typedef struct packed {
    logic en;
    logic [12:0] addr;
    logic [7:0] data;
  } pcs_fwr_t;

  // arithmetic flag results and which of them the instruction updates
  typedef struct packed {
    logic upd_z;
    logic upd_digit;
    logic upd_c;
    logic sub;
    logic zero;
    logic carry;
    logic dcarry;
    logic borrow;
    logic dborrow;
  } pcs_flags_t;

  // power and watchdog events driving the reset status bits
  typedef struct packed {
    logic clrwdt;
    logic sleep;
    logic wdt_timeout;
  } pcs_pwr_t;

endpackage : pcs_pkg
